// *** hw/mpp_defines.vh ***
// Behaviour
// R01: each discrete port pin is its own one-bit I/O, set and cleared alone.
// R02: every port bit selects open-drain or push-pull output driver.
// R03: software writes latch one and open-drain before reading a pin.
// R04: discrete bits two and three have pull-up and wakeup enables.
// R05: port zero is four-bit I/O with per-bit pull-up and wakeup.
// R06: port one is four-bit I/O with per-bit pull-up and wakeup.
// R07: port two is two-bit I/O with pull-up and wakeup.
// R08: port three is two-bit I/O with output structure only.
// R09: port zero bits 0,1,2 double as serial in, out and clock.
// R10: port one bits 1,2,3 double as timer pin b, a, interrupt.
// R11: analog channels 0-5 share port two, port three, discrete bits 2,3.
// R12: timer pin a is timer two count input and timer one pwm output.
// R13: timer pin b is timer one count input and timer two pwm output.
// R14: interrupt pin takes requests and has switchable wakeup.
// R15: port zero bit zero stays full I/O while serial input is used.
// R16: port zero bit one reads pin level while serial output drives.
// R17: port zero bit two reads pin level while serial clock uses it.
// R18: port one bit one readable when timer outputs, full I/O otherwise.
// R19: port one bit two readable when timer outputs, full I/O otherwise.
// R20: port one bit three stays full I/O with interrupt in use.
// R21: analog-shared bits stay full I/O while converter channels used.
// R22: output structure select zero gives open-drain, one push-pull.
// R23: pull-up control zero keeps the pull-up off.
// R24: wakeup control zero disables wakeup from that pin.
// R25: a selected driving alternate function replaces the latch output.
`ifndef MPP_DEFINES_VH
`define MPP_DEFINES_VH
// register byte offsets
`define MPP_ADR_DLAT   8'h00
`define MPP_ADR_DSTR   8'h04
`define MPP_ADR_DPU    8'h08
`define MPP_ADR_DWK    8'h0C
`define MPP_ADR_P0LAT  8'h10
`define MPP_ADR_P0STR  8'h14
`define MPP_ADR_P0PU   8'h18
`define MPP_ADR_P0WK   8'h1C
`define MPP_ADR_P1LAT  8'h20
`define MPP_ADR_P1STR  8'h24
`define MPP_ADR_P1PU   8'h28
`define MPP_ADR_P1WK   8'h2C
`define MPP_ADR_P2LAT  8'h30
`define MPP_ADR_P2STR  8'h34
`define MPP_ADR_P2PU   8'h38
`define MPP_ADR_P2WK   8'h3C
`define MPP_ADR_P3LAT  8'h40
`define MPP_ADR_P3STR  8'h44
`define MPP_ADR_DIN    8'h48
`define MPP_ADR_P0IN   8'h4C
`define MPP_ADR_P1IN   8'h50
`define MPP_ADR_P2IN   8'h54
`define MPP_ADR_P3IN   8'h58
`define MPP_ADR_DSET   8'h5C
`define MPP_ADR_DCLR   8'h60
`define MPP_ADR_WKST   8'h64
// reset values: latches high, open-drain, pull-up and wakeup off
`define MPP_RST_LAT    8'hFF
`define MPP_RST_CTL    8'h00
// discrete bits carrying pull-up and wakeup
`define MPP_D_OPT_MASK 6'h0C
`endif

// *** hw/mpp_pin.v ***
`timescale 1ns/100ps
`default_nettype none
// one pin: driver choice, pull-up, three-stage input sync, wakeup
module mpp_pin (
	input  wire clk_i,
	input  wire rst_i,
	input  wire out_val_i,
	input  wire push_pull_i,
	input  wire pu_en_i,
	input  wire wk_en_i,
	input  wire pad_i,
	output wire pad_o,
	output wire pad_oe_o,
	output wire pu_o,
	output reg  in_o,
	output wire wake_o
);
	reg s1_r;
	reg s2_r;
	reg s3_r;

	// open-drain drives only low, push-pull always [R22] [R02]
	assign pad_o    = out_val_i;
	assign pad_oe_o = push_pull_i | ~out_val_i;
	// pull-up on only when enabled [R23]
	assign pu_o     = pu_en_i;
	// wakeup on low level when enabled [R24]
	assign wake_o   = wk_en_i & ~in_o;

	// input synchroniser, change taken when stage two and three agree
	always @(posedge clk_i) begin
		if (rst_i) begin
			s1_r <= 1'b1;
			s2_r <= 1'b1;
			s3_r <= 1'b1;
			in_o <= 1'b1;
		end else begin
			s1_r <= pad_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r)
				in_o <= s3_r;
		end
	end
endmodule
`default_nettype wire

// *** hw/mpp_top.v ***
// Local design decisions: the placing of the registers and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
`include "mpp_defines.vh"
// multiplexed port pins with wishbone register access
module mpp_top (
	input  wire        clk_i,
	input  wire        rst_i,
	// wishbone classic slave
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [7:0]  adr_i,
	input  wire [3:0]  sel_i,
	input  wire [31:0] dat_i,
	output reg  [31:0] dat_o,
	output reg         ack_o,
	// pins: discrete, port zero..three
	input  wire [5:0]  d_pad_i,
	output wire [5:0]  d_pad_o,
	output wire [5:0]  d_pad_oe_o,
	output wire [5:0]  d_pu_o,
	input  wire [3:0]  p0_pad_i,
	output wire [3:0]  p0_pad_o,
	output wire [3:0]  p0_pad_oe_o,
	output wire [3:0]  p0_pu_o,
	input  wire [3:0]  p1_pad_i,
	output wire [3:0]  p1_pad_o,
	output wire [3:0]  p1_pad_oe_o,
	output wire [3:0]  p1_pu_o,
	input  wire [1:0]  p2_pad_i,
	output wire [1:0]  p2_pad_o,
	output wire [1:0]  p2_pad_oe_o,
	output wire [1:0]  p2_pu_o,
	input  wire [1:0]  p3_pad_i,
	output wire [1:0]  p3_pad_o,
	output wire [1:0]  p3_pad_oe_o,
	// serial function
	input  wire        ser_out_en_i,
	input  wire        ser_out_i,
	input  wire        ser_clk_out_en_i,
	input  wire        ser_clk_out_i,
	output wire        ser_in_o,
	output wire        ser_clk_in_o,
	// timers
	input  wire        tmr_a_pwm_en_i,
	input  wire        tmr_a_pwm_i,
	input  wire        tmr_b_pwm_en_i,
	input  wire        tmr_b_pwm_i,
	output wire        tmr_a_cnt_o,
	output wire        tmr_b_cnt_o,
	// interrupt, analog, wakeup
	output wire        ext_int_o,
	input  wire        int_wk_en_i,
	output wire [5:0]  analog_sel_o,
	output wire        wakeup_o
);
	// software-written state
	reg [5:0] d_lat_r, d_str_r, d_pu_r, d_wk_r;
	reg [3:0] p0_lat_r, p0_str_r, p0_pu_r, p0_wk_r;
	reg [3:0] p1_lat_r, p1_str_r, p1_pu_r, p1_wk_r;
	reg [1:0] p2_lat_r, p2_str_r, p2_pu_r, p2_wk_r;
	reg [1:0] p3_lat_r, p3_str_r;
	reg [31:0] rd_nxt;

	// reset constants kept at full width, sliced to each port
	localparam [7:0] LAT_RST = `MPP_RST_LAT;
	localparam [7:0] CTL_RST = `MPP_RST_CTL;

	wire [5:0] d_in, d_wk;
	wire [3:0] p0_in, p0_wk, p1_in, p1_wk;
	wire [1:0] p2_in, p2_wk, p3_in;
	wire [3:0] p0_out, p1_out;
	wire [5:0] d_pu_eff, d_wk_eff;

	wire wr = cyc_i & stb_i & we_i & ~ack_o & sel_i[0];
	wire [7:0] wd = dat_i[7:0];

	// alternate drivers replace the latch when enabled [R25]
	assign p0_out = {p0_lat_r[3],
		ser_clk_out_en_i ? ser_clk_out_i : p0_lat_r[2], // [R09] [R17]
		ser_out_en_i ? ser_out_i : p0_lat_r[1],         // [R09] [R16]
		p0_lat_r[0]};                                    // [R15]
	// timer pin a on bit 2, pin b on bit 1 [R10] [R12] [R13]
	assign p1_out = {p1_lat_r[3],                        // [R20]
		tmr_a_pwm_en_i ? tmr_a_pwm_i : p1_lat_r[2],     // [R19]
		tmr_b_pwm_en_i ? tmr_b_pwm_i : p1_lat_r[1],     // [R18]
		p1_lat_r[0]};

	// only discrete bits two and three carry options [R04]
	assign d_pu_eff = d_pu_r & `MPP_D_OPT_MASK;
	assign d_wk_eff = d_wk_r & `MPP_D_OPT_MASK;

	// independent single-bit discrete pins [R01]
	genvar g;
	generate
		for (g = 0; g < 6; g = g + 1) begin : g_d
			mpp_pin u_pin (
				.clk_i(clk_i), .rst_i(rst_i),
				.out_val_i(d_lat_r[g]), .push_pull_i(d_str_r[g]),
				.pu_en_i(d_pu_eff[g]), .wk_en_i(d_wk_eff[g]),
				.pad_i(d_pad_i[g]), .pad_o(d_pad_o[g]),
				.pad_oe_o(d_pad_oe_o[g]), .pu_o(d_pu_o[g]),
				.in_o(d_in[g]), .wake_o(d_wk[g]));
		end
		// port zero four bits [R05]
		for (g = 0; g < 4; g = g + 1) begin : g_p0
			mpp_pin u_pin (
				.clk_i(clk_i), .rst_i(rst_i),
				.out_val_i(p0_out[g]), .push_pull_i(p0_str_r[g]),
				.pu_en_i(p0_pu_r[g]), .wk_en_i(p0_wk_r[g]),
				.pad_i(p0_pad_i[g]), .pad_o(p0_pad_o[g]),
				.pad_oe_o(p0_pad_oe_o[g]), .pu_o(p0_pu_o[g]),
				.in_o(p0_in[g]), .wake_o(p0_wk[g]));
		end
		// port one four bits; bit three wakeup also by int enable [R06] [R14]
		for (g = 0; g < 4; g = g + 1) begin : g_p1
			mpp_pin u_pin (
				.clk_i(clk_i), .rst_i(rst_i),
				.out_val_i(p1_out[g]), .push_pull_i(p1_str_r[g]),
				.pu_en_i(p1_pu_r[g]),
				.wk_en_i(p1_wk_r[g] | (g == 3 && int_wk_en_i)),
				.pad_i(p1_pad_i[g]), .pad_o(p1_pad_o[g]),
				.pad_oe_o(p1_pad_oe_o[g]), .pu_o(p1_pu_o[g]),
				.in_o(p1_in[g]), .wake_o(p1_wk[g]));
		end
		// port two two bits [R07]
		for (g = 0; g < 2; g = g + 1) begin : g_p2
			mpp_pin u_pin (
				.clk_i(clk_i), .rst_i(rst_i),
				.out_val_i(p2_lat_r[g]), .push_pull_i(p2_str_r[g]),
				.pu_en_i(p2_pu_r[g]), .wk_en_i(p2_wk_r[g]),
				.pad_i(p2_pad_i[g]), .pad_o(p2_pad_o[g]),
				.pad_oe_o(p2_pad_oe_o[g]), .pu_o(p2_pu_o[g]),
				.in_o(p2_in[g]), .wake_o(p2_wk[g]));
		end
		// port three: structure select only [R08]
		for (g = 0; g < 2; g = g + 1) begin : g_p3
			mpp_pin u_pin (
				.clk_i(clk_i), .rst_i(rst_i),
				.out_val_i(p3_lat_r[g]), .push_pull_i(p3_str_r[g]),
				.pu_en_i(1'b0), .wk_en_i(1'b0),
				.pad_i(p3_pad_i[g]), .pad_o(p3_pad_o[g]),
				.pad_oe_o(p3_pad_oe_o[g]), .pu_o(),
				.in_o(p3_in[g]), .wake_o());
		end
	endgenerate

	// alternate inputs read from the same synchronised pins [R09] [R15]
	assign ser_in_o     = p0_in[0];
	assign ser_clk_in_o = p0_in[2];
	assign tmr_a_cnt_o  = p1_in[2];   // [R12]
	assign tmr_b_cnt_o  = p1_in[1];   // [R13]
	assign ext_int_o    = p1_in[3];   // [R14] [R20]
	// analog channels map; port logic untouched [R11] [R21]
	assign analog_sel_o = {d_in[3], d_in[2], p3_in, p2_in};
	assign wakeup_o = |{d_wk, p0_wk, p1_wk, p2_wk};

	// register writes
	always @(posedge clk_i) begin
		if (rst_i) begin
			d_lat_r  <= LAT_RST[5:0];
			d_str_r  <= CTL_RST[5:0];
			d_pu_r   <= CTL_RST[5:0];
			d_wk_r   <= CTL_RST[5:0];
			p0_lat_r <= LAT_RST[3:0];
			p0_str_r <= CTL_RST[3:0];
			p0_pu_r  <= CTL_RST[3:0];
			p0_wk_r  <= CTL_RST[3:0];
			p1_lat_r <= LAT_RST[3:0];
			p1_str_r <= CTL_RST[3:0];
			p1_pu_r  <= CTL_RST[3:0];
			p1_wk_r  <= CTL_RST[3:0];
			p2_lat_r <= LAT_RST[1:0];
			p2_str_r <= CTL_RST[1:0];
			p2_pu_r  <= CTL_RST[1:0];
			p2_wk_r  <= CTL_RST[1:0];
			p3_lat_r <= LAT_RST[1:0];
			p3_str_r <= CTL_RST[1:0];
		end else if (wr) begin
			if (adr_i == `MPP_ADR_DLAT) d_lat_r <= wd[5:0];
			else if (adr_i == `MPP_ADR_DSTR) d_str_r <= wd[5:0];
			else if (adr_i == `MPP_ADR_DPU) d_pu_r <= wd[5:0];
			else if (adr_i == `MPP_ADR_DWK) d_wk_r <= wd[5:0];
			else if (adr_i == `MPP_ADR_P0LAT) p0_lat_r <= wd[3:0];
			else if (adr_i == `MPP_ADR_P0STR) p0_str_r <= wd[3:0];
			else if (adr_i == `MPP_ADR_P0PU) p0_pu_r <= wd[3:0];
			else if (adr_i == `MPP_ADR_P0WK) p0_wk_r <= wd[3:0];
			else if (adr_i == `MPP_ADR_P1LAT) p1_lat_r <= wd[3:0];
			else if (adr_i == `MPP_ADR_P1STR) p1_str_r <= wd[3:0];
			else if (adr_i == `MPP_ADR_P1PU) p1_pu_r <= wd[3:0];
			else if (adr_i == `MPP_ADR_P1WK) p1_wk_r <= wd[3:0];
			else if (adr_i == `MPP_ADR_P2LAT) p2_lat_r <= wd[1:0];
			else if (adr_i == `MPP_ADR_P2STR) p2_str_r <= wd[1:0];
			else if (adr_i == `MPP_ADR_P2PU) p2_pu_r <= wd[1:0];
			else if (adr_i == `MPP_ADR_P2WK) p2_wk_r <= wd[1:0];
			else if (adr_i == `MPP_ADR_P3LAT) p3_lat_r <= wd[1:0];
			else if (adr_i == `MPP_ADR_P3STR) p3_str_r <= wd[1:0];
			// single discrete bit set or clear by index [R01]
			else if (adr_i == `MPP_ADR_DSET && wd[2:0] < 3'd6)
				d_lat_r[wd[2:0]] <= 1'b1;
			else if (adr_i == `MPP_ADR_DCLR && wd[2:0] < 3'd6)
				d_lat_r[wd[2:0]] <= 1'b0;
		end
	end

	// read mux; inputs show pin level regardless of function [R16] [R17]
	always @* begin
		rd_nxt = 32'h0000_0000;
		if (adr_i == `MPP_ADR_DLAT) rd_nxt[5:0] = d_lat_r;
		else if (adr_i == `MPP_ADR_DSTR) rd_nxt[5:0] = d_str_r;
		else if (adr_i == `MPP_ADR_DPU) rd_nxt[5:0] = d_pu_eff;
		else if (adr_i == `MPP_ADR_DWK) rd_nxt[5:0] = d_wk_eff;
		else if (adr_i == `MPP_ADR_P0LAT) rd_nxt[3:0] = p0_lat_r;
		else if (adr_i == `MPP_ADR_P0STR) rd_nxt[3:0] = p0_str_r;
		else if (adr_i == `MPP_ADR_P0PU) rd_nxt[3:0] = p0_pu_r;
		else if (adr_i == `MPP_ADR_P0WK) rd_nxt[3:0] = p0_wk_r;
		else if (adr_i == `MPP_ADR_P1LAT) rd_nxt[3:0] = p1_lat_r;
		else if (adr_i == `MPP_ADR_P1STR) rd_nxt[3:0] = p1_str_r;
		else if (adr_i == `MPP_ADR_P1PU) rd_nxt[3:0] = p1_pu_r;
		else if (adr_i == `MPP_ADR_P1WK) rd_nxt[3:0] = p1_wk_r;
		else if (adr_i == `MPP_ADR_P2LAT) rd_nxt[1:0] = p2_lat_r;
		else if (adr_i == `MPP_ADR_P2STR) rd_nxt[1:0] = p2_str_r;
		else if (adr_i == `MPP_ADR_P2PU) rd_nxt[1:0] = p2_pu_r;
		else if (adr_i == `MPP_ADR_P2WK) rd_nxt[1:0] = p2_wk_r;
		else if (adr_i == `MPP_ADR_P3LAT) rd_nxt[1:0] = p3_lat_r;
		else if (adr_i == `MPP_ADR_P3STR) rd_nxt[1:0] = p3_str_r;
		else if (adr_i == `MPP_ADR_DIN) rd_nxt[5:0] = d_in;
		else if (adr_i == `MPP_ADR_P0IN) rd_nxt[3:0] = p0_in;
		else if (adr_i == `MPP_ADR_P1IN) rd_nxt[3:0] = p1_in; // [R18]
		else if (adr_i == `MPP_ADR_P2IN) rd_nxt[1:0] = p2_in;
		else if (adr_i == `MPP_ADR_P3IN) rd_nxt[1:0] = p3_in;
		else if (adr_i == `MPP_ADR_WKST)
			rd_nxt[15:0] = {p2_wk, p1_wk, p0_wk, d_wk};
	end

	// one-cycle ack, data registered with it
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= cyc_i & stb_i & ~ack_o;
			dat_o <= rd_nxt;
		end
	end
endmodule
`default_nettype wire

// *** sim/mpp_top_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
// watches bus handshake and pin muxing at the top ports
module mpp_top_chk (
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       cyc_i,
	input wire logic       stb_i,
	input wire logic       ack_o,
	input wire logic [5:0] d_pad_i,
	input wire logic [5:0] d_pu_o,
	input wire logic [3:0] p0_pad_i,
	input wire logic [3:0] p0_pad_o,
	input wire logic [3:0] p1_pad_o,
	input wire logic [1:0] p2_pad_i,
	input wire logic [1:0] p3_pad_i,
	input wire logic       ser_out_en_i,
	input wire logic       ser_out_i,
	input wire logic       tmr_a_pwm_en_i,
	input wire logic       tmr_a_pwm_i,
	input wire logic       tmr_b_pwm_en_i,
	input wire logic       tmr_b_pwm_i,
	input wire logic       ser_in_o,
	input wire logic [5:0] analog_sel_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// bus answer one cycle after a new request, for one cycle
	property p_ack; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
	property p_pulse; ack_o |=> !ack_o; endproperty
	// driving alternate functions own the pin value
	property p_sout; ser_out_en_i |-> p0_pad_o[1] == ser_out_i; endproperty
	property p_tmra; tmr_a_pwm_en_i |-> p1_pad_o[2] == tmr_a_pwm_i; endproperty
	property p_tmrb; tmr_b_pwm_en_i |-> p1_pad_o[1] == tmr_b_pwm_i; endproperty
	// only discrete bits two and three may pull up
	property p_dpu; (d_pu_o & 6'h33) == 6'h00; endproperty
	// settled pin levels reach the alternate inputs
	property p_sin;
		($stable(p0_pad_i[0]))[*5] |-> ser_in_o == p0_pad_i[0];
	endproperty
	property p_ana;
		($stable({d_pad_i[3:2], p3_pad_i, p2_pad_i}))[*5]
			|-> analog_sel_o == {d_pad_i[3:2], p3_pad_i, p2_pad_i};
	endproperty
	a_ack: assert property (p_ack)
		else $error("no ack after request");
	a_pulse: assert property (p_pulse)
		else $error("ack longer than one cycle");
	a_sout: assert property (p_sout)
		else $error("serial out not on pin");
	a_tmra: assert property (p_tmra)
		else $error("timer a pwm not on pin");
	a_tmrb: assert property (p_tmrb)
		else $error("timer b pwm not on pin");
	a_dpu: assert property (p_dpu)
		else $error("pull-up on a discrete bit without one");
	a_sin: assert property (p_sin)
		else $error("serial in does not follow pin");
	a_ana: assert property (p_ana)
		else $error("analog select does not follow pins");
	c_ack: cover property (ack_o);
	c_sout: cover property (ser_out_en_i && ser_out_i);
	c_tmr: cover property (tmr_a_pwm_en_i && tmr_b_pwm_en_i);
endmodule
`default_nettype wire

// *** sim/mpp_board.sv ***
`timescale 1ns/100ps
`default_nettype none
// board side: drives released pins, else pull-up, else floats
module mpp_board #(parameter int W = 18) (
	input  wire logic         clk_i,
	input  wire logic [W-1:0] o_i,
	input  wire logic [W-1:0] oe_i,
	input  wire logic [W-1:0] pu_i,
	input  wire logic [W-1:0] ev_i,
	input  wire logic [W-1:0] ee_i,
	output logic      [W-1:0] lvl_o
);
	logic tog_r = 1'b0;
	// floating lines toggle every clock, so the pin synchroniser keeps its last value
	always @(posedge clk_i) tog_r <= ~tog_r;
	// resolve each line from all drivers
	always_comb begin
		for (int i = 0; i < W; i++)
			lvl_o[i] = oe_i[i] ? o_i[i] : ee_i[i] ? ev_i[i] :
				pu_i[i] ? 1'b1 : tog_r;
	end
endmodule
`default_nettype wire

// *** sim/mpp_top_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "mpp_defines.vh"
module mpp_top_bench;
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
	logic [7:0] adr_i = 0;
	logic [3:0] sel_i = 4'hF;
	logic [31:0] dat_i = 0, q;
	logic ser_out_en_i = 0, ser_out_i = 0, ser_clk_out_en_i = 0;
	logic ser_clk_out_i = 0, tmr_a_pwm_en_i = 0, tmr_a_pwm_i = 0;
	logic tmr_b_pwm_en_i = 0, tmr_b_pwm_i = 0, int_wk_en_i = 0;
	logic [17:0] ev = 0, ee = 0;
	wire [31:0] dat_o;
	wire [17:0] lvl;
	wire [5:0] d_pad_i, d_pad_o, d_pad_oe_o, d_pu_o, analog_sel_o;
	wire [3:0] p0_pad_i, p0_pad_o, p0_pad_oe_o, p0_pu_o;
	wire [3:0] p1_pad_i, p1_pad_o, p1_pad_oe_o, p1_pu_o;
	wire [1:0] p2_pad_i, p2_pad_o, p2_pad_oe_o, p2_pu_o;
	wire [1:0] p3_pad_i, p3_pad_o, p3_pad_oe_o;
	wire ack_o, ser_in_o, ser_clk_in_o, tmr_a_cnt_o, tmr_b_cnt_o;
	wire ext_int_o, wakeup_o;
	int fail_count = 0, checks = 0, cyc_n = 0;
	mpp_top DUT (.*);
	mpp_board BRD (.clk_i(clk_i), .ev_i(ev), .ee_i(ee), .lvl_o(lvl),
		.o_i({d_pad_o, p0_pad_o, p1_pad_o, p2_pad_o, p3_pad_o}),
		.oe_i({d_pad_oe_o, p0_pad_oe_o, p1_pad_oe_o, p2_pad_oe_o,
			p3_pad_oe_o}),
		.pu_i({d_pu_o, p0_pu_o, p1_pu_o, p2_pu_o, 2'h0}));
	assign {d_pad_i, p0_pad_i, p1_pad_i, p2_pad_i, p3_pad_i} = lvl;
	always #12.5 clk_i = ~clk_i;
	// verdict and end of run
	task end_of_test;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// cycle ceiling cuts a hang short
	always @(posedge clk_i) begin
		cyc_n++;
		if (cyc_n == 5000) begin
			fail_count++;
			end_of_test;
		end
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			fail_count++;
			$display("ERROR t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	// one classic wishbone cycle, held until ack
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc_i <= 1;
		stb_i <= 1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o;
		cyc_i <= 0;
		stb_i <= 0;
	endtask
	task rc(input logic [7:0] a, input logic [31:0] e);
		wb(0, a, 0);
		chk(q, e);
	endtask
	task pause(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	initial begin
		pause(10);
		rst_i <= 0;
		chk({d_pad_oe_o, p0_pad_oe_o, p1_pad_oe_o}, 0);
		chk({p2_pad_oe_o, p3_pad_oe_o}, 0);
		chk({p2_pad_o, p3_pad_o}, 4'hF);
		rc(`MPP_ADR_DSTR, 0);
		// single discrete bits set and cleared
		wb(1, `MPP_ADR_DSTR, 6'h3F);
		wb(1, `MPP_ADR_DLAT, 6'h3F);
		wb(1, `MPP_ADR_DCLR, 2);
		chk(d_pad_o, 6'h3B);
		chk(d_pad_oe_o, 6'h3F);
		wb(1, `MPP_ADR_DSET, 2);
		wb(1, `MPP_ADR_DCLR, 5);
		rc(`MPP_ADR_DLAT, 6'h1F);
		wb(1, `MPP_ADR_P3STR, 2'h3);
		wb(1, `MPP_ADR_P3LAT, 2'h2);
		chk({p3_pad_oe_o, p3_pad_o}, 4'hE);
		$display("test discrete done");
		// open-drain drives low only; input after latch one
		wb(1, `MPP_ADR_DSTR, 0);
		wb(1, `MPP_ADR_DLAT, 6'h2A);
		chk(d_pad_oe_o, 6'h15);
		wb(1, `MPP_ADR_DLAT, 6'h3F);
		ee <= 18'h3F000;
		ev <= 18'h25000;
		pause(6);
		rc(`MPP_ADR_DIN, 6'h25);
		ee <= 0;
		$display("test input done");
		// pull-ups on, then off
		for (int i = 0; i < 4; i++)
			wb(1, 8'h08 + 8'h10 * i, 8'hFF);
		chk({d_pu_o, p0_pu_o, p1_pu_o, p2_pu_o}, 16'h33FF);
		chk(p2_pu_o, 2'h3);
		for (int i = 0; i < 4; i++)
			wb(1, 8'h08 + 8'h10 * i, 0);
		chk({d_pu_o, p0_pu_o, p1_pu_o, p2_pu_o}, 0);
		$display("test pull-up done");
		// wakeup on a low pin, masked by its control bit
		ee <= 18'h00F80;
		wb(1, `MPP_ADR_P0WK, 1);
		pause(5);
		chk(wakeup_o, 1);
		wb(1, `MPP_ADR_P0WK, 0);
		chk(wakeup_o, 0);
		int_wk_en_i <= 1;
		pause(5);
		chk(wakeup_o, 1);
		chk(ext_int_o, 0);
		int_wk_en_i <= 0;
		// discrete wakeup only on bits two and three
		ee <= 18'h3_F000;
		ev <= 18'h0_0000;
		wb(1, `MPP_ADR_DWK, 6'h3F);
		pause(5);
		rc(`MPP_ADR_WKST, 32'h0000_000C);
		rc(`MPP_ADR_DWK, 32'h0000_000C);
		chk(wakeup_o, 1);
		wb(1, `MPP_ADR_DWK, 0);
		ee <= 0;
		$display("test wakeup done");
		// alternate outputs take over, port still reads pin
		wb(1, `MPP_ADR_P0STR, 4'hF);
		wb(1, `MPP_ADR_P1STR, 4'hF);
		for (int v = 0; v < 2; v++) begin
			ser_out_en_i <= 1;
			ser_clk_out_en_i <= 1;
			tmr_a_pwm_en_i <= 1;
			tmr_b_pwm_en_i <= 1;
			ser_out_i <= v[0];
			ser_clk_out_i <= v[0];
			tmr_a_pwm_i <= v[0];
			tmr_b_pwm_i <= !v[0];
			pause(6);
			chk(p0_pad_o[1], v[0]);
			rc(`MPP_ADR_P0IN, {1'b1, v[0], v[0], 1'b1});
			rc(`MPP_ADR_P1IN, {1'b1, v[0], !v[0], 1'b1});
			chk({tmr_a_cnt_o, tmr_b_cnt_o}, {v[0], !v[0]});
			chk(ser_clk_in_o, v[0]);
		end
		ser_out_en_i <= 0;
		ser_clk_out_en_i <= 0;
		tmr_a_pwm_en_i <= 0;
		tmr_b_pwm_en_i <= 0;
		$display("test alternate done");
		// every pin released, board drives a pattern
		for (int i = 0; i < 5; i++)
			wb(1, 8'h04 + 8'h10 * i, 0);
		wb(1, `MPP_ADR_P3LAT, 2'h3);
		ee <= 18'h3FFFF;
		ev <= 18'h2C6A6;
		pause(6);
		chk(analog_sel_o, 6'h39);
		chk({ser_in_o, ext_int_o, tmr_b_cnt_o}, 3'h3);
		rc(`MPP_ADR_P0IN, 4'h6);
		rc(`MPP_ADR_P1IN, 4'hA);
		rc(`MPP_ADR_P2IN, 2'h1);
		rc(`MPP_ADR_P3IN, 2'h2);
		rc(`MPP_ADR_DIN, 6'h2C);
		// unmapped place and masked byte write
		wb(1, 8'h7C, 8'hFF);
		rc(8'h7C, 0);
		sel_i <= 0;
		wb(1, `MPP_ADR_DLAT, 0);
		sel_i <= 4'hF;
		rc(`MPP_ADR_DLAT, 6'h3F);
		$display("test shared inputs done");
		end_of_test;
	end
endmodule
bind mpp_top mpp_top_chk chk (
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
	.ack_o(ack_o), .d_pad_i(d_pad_i), .d_pu_o(d_pu_o),
	.p0_pad_i(p0_pad_i), .p0_pad_o(p0_pad_o), .p1_pad_o(p1_pad_o),
	.p2_pad_i(p2_pad_i), .p3_pad_i(p3_pad_i),
	.ser_out_en_i(ser_out_en_i), .ser_out_i(ser_out_i),
	.tmr_a_pwm_en_i(tmr_a_pwm_en_i), .tmr_a_pwm_i(tmr_a_pwm_i),
	.tmr_b_pwm_en_i(tmr_b_pwm_en_i), .tmr_b_pwm_i(tmr_b_pwm_i),
	.ser_in_o(ser_in_o), .analog_sel_o(analog_sel_o));
`default_nettype wire
